// ### core/asm_acq_memory.sv
// acquisition sample memory: converter capture, four-phase byte demux,
// eight 4-bit x 256 sample rams, write counter, relative read adder, slot
// select and board type answer. assumes all timing inputs are asynchronous.
//
// What this block does
// (R1) each converter: 7 bits, six magnitude plus overrange, wired together
// (R2) a new converter sample is taken on every master clock cycle
// (R3) four 8-bit latches build a 32-bit word written as two 16-bit halves
// (R4) the four phase clocks are staggered a quarter period apart
// (R5) eight 4-bit rams with 8-bit address; each latch byte feeds a ram pair
// (R6) timing unit derives strobes, phase clocks, address clock from inputs
// (R7) 8-bit write counter increments on each address clock while gated
// (R8) write counter has no clear, load or readback
// (R9) write counter holds when acquisition stops, one past the last written location
// (R10) write address register captures counter on address clock for strobes
// (R11) read address is write address plus bus address bits 3 to 10
// (R12) host supplies the relative offset on the bus address lines
// (R13) write counter addresses the ram writes; registered write address drives ramAddr when unselected
// (R14) adder read address drives the ram address during reads
// (R15) only the first phase byte (rams 0 and 1) is presented on an 8-bit data buffer
// (R16) slot address bits 19 to 22 compared with slot identity make select
// (R17) select latch gives read enable, write-path enable and acknowledge
// (R18) board type request returns a fixed 4-bit code on data bits 0 to 3
// (R19) host only reads this board, never writes
// (R20) after trigger storage stops while conversion continues, data dropped
// (R21) sample-memory clocks set the storage rate
// (R22) first phase byte is the least significant byte of the word
`default_nettype none
module asm_acq_memory
    import asm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic [SAMPLE_W-1:0]   convPos,
    input  wire logic [SAMPLE_W-1:0]   convNeg,
    input  wire logic                  sample_mem_clk_a,
    input  wire logic                  sample_mem_clk_b,
    input  wire logic                  acq_gate,
    input  wire logic [SLOT_W-1:0]     slot_ident,
    input  wire asm_bus_req_t          busReq,
    output asm_bus_rsp_t               busRsp,
    output logic                       rd_path_en_n,
    output logic                       wr_path_en,
    output logic                       wstrobe_lo_n,
    output logic                       wstrobe_hi_n,
    output logic [NUM_PHASE-1:0]       phase_clk,
    output logic                       waddr_clk,
    output logic [ADDR_W-1:0]          ramAddr
);

    // adds offset to base, wrapping at eight bits
    function automatic logic [ADDR_W-1:0] addWrap(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] b
    );
        addWrap = a + b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // clock and gate pins: three flops, a change counts when stages two and three agree; converters one flop
    logic [2:0] smA_q, smB_q, gate_q;
    logic [2:0] smA_d, smB_d, gate_d;
    logic       smAStable_q, smBStable_q, gateStable_q;
    logic       smAStable_d, smBStable_d, gateStable_d;
    logic [SAMPLE_W-1:0] conv_q, conv_d;

    always_comb begin
        smA_d  = {smA_q[1:0], sample_mem_clk_a};
        smB_d  = {smB_q[1:0], sample_mem_clk_b};
        gate_d = {gate_q[1:0], acq_gate};
        smAStable_d  = (smA_q[2] == smA_q[1]) ? smA_q[2] : smAStable_q;
        smBStable_d  = (smB_q[2] == smB_q[1]) ? smB_q[2] : smBStable_q;
        gateStable_d = (gate_q[2] == gate_q[1]) ? gate_q[2] : gateStable_q;
        // both converters share one bus; wired bits combine
        conv_d = convPos | convNeg;                       // R1 R2
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            smA_q        <= 3'h0;
            smB_q        <= 3'h0;
            gate_q       <= 3'h0;
            smAStable_q  <= 1'h0;
            smBStable_q  <= 1'h0;
            gateStable_q <= 1'h0;
            conv_q       <= 7'h00;
        end else begin
            smA_q        <= smA_d;
            smB_q        <= smB_d;
            gate_q       <= gate_d;
            smAStable_q  <= smAStable_d;
            smBStable_q  <= smBStable_d;
            gateStable_q <= gateStable_d;
            conv_q       <= conv_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timing unit: storage paced by sample-memory clock rising edges
    logic smAPrev_q, smAPrev_d;
    logic smBPrev_q, smBPrev_d;
    logic storeTick;
    logic [1:0] phase_q, phase_d;
    logic [NUM_PHASE-1:0] phaseClk_q, phaseClk_d;
    logic [BYTE_W-1:0] lane_q [NUM_PHASE];
    logic [BYTE_W-1:0] lane_d [NUM_PHASE];
    logic weLoN_q, weLoN_d, weHiN_q, weHiN_d, aclk_q, aclk_d;

    always_comb begin
        smAPrev_d = smAStable_q;
        smBPrev_d = smBStable_q;
        // either clock edge stores; gate low drops conversions
        storeTick = gateStable_q &&                        // R20 R21
                    ((smAStable_q && !smAPrev_q) ||
                     (smBStable_q && !smBPrev_q));
        phase_d    = phase_q;
        phaseClk_d = '0;
        weLoN_d    = 1'b1;
        weHiN_d    = 1'b1;
        aclk_d     = 1'b0;
        for (int i = 0; i < NUM_PHASE; i++) lane_d[i] = lane_q[i];
        if (!gateStable_q) begin
            phase_d = PHASE_RST;
        end else if (storeTick) begin
            // one phase per tick: quarter-period stagger
            phaseClk_d[phase_q] = 1'b1;                    // R4 R6
            lane_d[phase_q] = {1'b0, conv_q};              // R22
            phase_d = phase_q + 2'h1;
            // low half written after phase 2, high after phase 4
            if (phase_q == 2'h1) weLoN_d = 1'b0;           // R3
            if (phase_q == 2'h3) begin
                weHiN_d = 1'b0;                            // R3
                aclk_d = 1'b1;                             // R6
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            smAPrev_q  <= 1'h0;
            smBPrev_q  <= 1'h0;
            phase_q    <= PHASE_RST;
            phaseClk_q <= 4'h0;
            weLoN_q    <= 1'h1;
            weHiN_q    <= 1'h1;
            aclk_q     <= 1'h0;
            for (int i = 0; i < NUM_PHASE; i++) lane_q[i] <= 8'h00;
        end else begin
            smAPrev_q  <= smAPrev_d;
            smBPrev_q  <= smBPrev_d;
            phase_q    <= phase_d;
            phaseClk_q <= phaseClk_d;
            weLoN_q    <= weLoN_d;
            weHiN_q    <= weHiN_d;
            aclk_q     <= aclk_d;
            for (int i = 0; i < NUM_PHASE; i++) lane_q[i] <= lane_d[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write counter: no clear, no load; reset only pins simulation x away
    logic [ADDR_W-1:0] wcnt_q, wcnt_d, waddr_q, waddr_d;

    always_comb begin
        wcnt_d  = wcnt_q;                                  // R8 R9
        waddr_d = waddr_q;
        if (aclk_q) begin
            waddr_d = wcnt_q;                              // R10
            wcnt_d  = addWrap(wcnt_q, 8'h01);              // R7
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wcnt_q  <= 8'h00;
            waddr_q <= 8'h00;
        end else begin
            wcnt_q  <= wcnt_d;
            waddr_q <= waddr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // eight nibble rams; ram 2k/2k+1 hold low/high nibble of lane k
    logic [NIBBLE_W-1:0] ram [NUM_RAM][DEPTH];             // R5
    logic [WORD_W-1:0]   word;

    always_comb begin
        for (int i = 0; i < NUM_PHASE; i++)
            word[i*BYTE_W +: BYTE_W] = lane_q[i];
    end

    always_ff @(posedge clk) begin
        for (int r = 0; r < NUM_RAM; r++) begin
            // rams 0..3 on the low half strobe, 4..7 on the high
            if ((r < 4 && !weLoN_q) || (r >= 4 && !weHiN_q)) // R3 R5
                ram[r][wcnt_q] <= word[r*NIBBLE_W +: NIBBLE_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus side: slot match, select latch, read address, data buffer
    logic              slotHit;
    logic [ADDR_W-1:0] rdAddr;
    logic              selN_q, selN_d;
    logic [BYTE_W-1:0] data_q, data_d;
    logic [ADDR_W-1:0] ramAddr_q, ramAddr_d;
    logic              wrEn_q, wrEn_d;

    always_comb begin
        slotHit = busReq.strobe &&                          // R16
            (busReq.addr[SLOT_LSB +: SLOT_W] == slot_ident);
        rdAddr  = addWrap(waddr_q,                          // R11 R12
                          busReq.addr[OFS_LSB +: ADDR_W]);
        selN_d  = !slotHit;                                 // R17 R19
        data_d  = data_q;
        // write address owns the ram bus unless a read is selected
        ramAddr_d = slotHit ? rdAddr : waddr_q;             // R13 R14
        wrEn_d    = !slotHit;                               // R13
        if (slotHit) begin
            if (busReq.addr[TYPE_SEL_BIT]) begin
                data_d = ZERO8;
                data_d[TYPE_LSB +: 4] = BOARD_TYPE;          // R18
            end else begin
                data_d = {ram[1][rdAddr], ram[0][rdAddr]};   // R15
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            selN_q    <= 1'h1;
            data_q    <= 8'h00;
            ramAddr_q <= 8'h00;
            wrEn_q    <= 1'h1;
        end else begin
            selN_q    <= selN_d;
            data_q    <= data_d;
            ramAddr_q <= ramAddr_d;
            wrEn_q    <= wrEn_d;
        end
    end

    // outputs straight from flops; active-low ones are stored inverted so
    // no gate sits between a register and its pin
    assign busRsp       = {selN_q, data_q};
    assign rd_path_en_n = selN_q;
    assign wr_path_en   = wrEn_q;
    assign wstrobe_lo_n = weLoN_q;
    assign wstrobe_hi_n = weHiN_q;
    assign phase_clk    = phaseClk_q;
    assign waddr_clk    = aclk_q;
    assign ramAddr      = ramAddr_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_ack_one_after;
        @(posedge clk) disable iff (reset)
        slotHit |=> !busRsp.ackN;
    endproperty
    a_ack_one_after: assert property (p_ack_one_after) // R16
        else $error("acknowledge missing after slot match");

    property p_no_ack_unselected;
        @(posedge clk) disable iff (reset)
        !slotHit |=> busRsp.ackN && rd_path_en_n && wr_path_en;
    endproperty
    a_no_ack_unselected: assert property (p_no_ack_unselected) // R17
        else $error("select asserted without slot match");

    property p_type_code;
        @(posedge clk) disable iff (reset)
        slotHit && busReq.addr[TYPE_SEL_BIT] |=>
            busRsp.data == {4'h0, BOARD_TYPE};
    endproperty
    a_type_code: assert property (p_type_code) // R18
        else $error("wrong board type code");

    property p_read_addr;
        @(posedge clk) disable iff (reset)
        slotHit |=> ramAddr == $past(rdAddr);
    endproperty
    a_read_addr: assert property (p_read_addr) // R11
        else $error("read address not base plus offset");

    property p_count_step;
        @(posedge clk) disable iff (reset)
        waddr_clk |=> wcnt_q == $past(wcnt_q) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) // R7
        else $error("write counter did not step");

    property p_count_hold;
        @(posedge clk) disable iff (reset)
        !waddr_clk |=> $stable(wcnt_q);
    endproperty
    a_count_hold: assert property (p_count_hold) // R9
        else $error("write counter moved without address clock");

    property p_no_store_ungated;
        @(posedge clk) disable iff (reset)
        !gateStable_q |=> phase_clk == 4'h0 && wstrobe_lo_n && wstrobe_hi_n;
    endproperty
    a_no_store_ungated: assert property (p_no_store_ungated) // R20
        else $error("storage while gate low");

    // plain boolean form: an implication may not be an operand of &&
    property p_phase_onehot;
        @(posedge clk) disable iff (reset)
        $onehot0(phase_clk) && (wstrobe_hi_n || phase_clk[3]);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) // R4
        else $error("phase clocks overlap or high strobe misplaced");

    property p_addr_latch;
        @(posedge clk) disable iff (reset)
        waddr_clk |=> waddr_q == $past(wcnt_q);
    endproperty
    a_addr_latch: assert property (p_addr_latch) // R10
        else $error("write address register missed counter");

endmodule
`default_nettype wire

// ### core/asm_pkg.sv
// package for the acquisition sample memory block: widths, bus fields,
// board type code and the carrier structs shared by the design.
// assumes a single 50 MHz clock with a synchronous active-high reset.
`default_nettype none
package asm_pkg;
    localparam int SAMPLE_W     = 7;          // six magnitude bits + overrange
    localparam int MAG_W        = 6;
    localparam int BYTE_W       = 8;
    localparam int WORD_W       = 32;
    localparam int HALF_W       = 16;
    localparam int NIBBLE_W     = 4;
    localparam int ADDR_W       = 8;
    localparam int NUM_PHASE    = 4;
    localparam int NUM_RAM      = 8;
    localparam int DEPTH        = 256;
    localparam int SLOT_W       = 4;
    localparam int OFS_LSB      = 3;          // bus address bits 3..10
    localparam int SLOT_LSB     = 19;         // bus address bits 19..22
    localparam int BUS_ADDR_W   = 23;
    localparam int TYPE_LSB     = 0;          // type code on data bits 0..3
    localparam int TYPE_SEL_BIT = 1;          // address bit picking type read
    // board type code: value arbitrary
    localparam logic [3:0] BOARD_TYPE = 4'h5;
    localparam logic [1:0] PHASE_RST  = 2'h0;
    localparam logic [7:0] ZERO8      = 8'h00;

    typedef struct packed {
        logic                     strobe;     // one-cycle read request
        logic [BUS_ADDR_W-1:0]    addr;
    } asm_bus_req_t;

    typedef struct packed {
        logic                 ackN;           // active-low acknowledge
        logic [BYTE_W-1:0]    data;
    } asm_bus_rsp_t;
endpackage
`default_nettype wire

// ### sim/asm_host_model.sv
// host side of the slot-addressed read bus: issues read requests and
// waits a bounded time for the acknowledge. assumes one clock, and
// that the caller starts a read only after reset has been released.
`default_nettype none
module asm_host_model
    import asm_pkg::*;
(
    input  wire logic         clk,
    output asm_bus_req_t      busReq,
    input  wire asm_bus_rsp_t busRsp
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // idle request at time zero
    initial begin
        busReq = '0;
    end

    // one read: strobe for one cycle, then look for the ack pulse.
    // the address is inverted once released so a stale value never helps
    task automatic read(input  logic [BUS_ADDR_W-1:0] a,
                        output logic [BYTE_W-1:0]     d,
                        output logic                  ok);
        int i;
        @(posedge clk);
        #1;
        busReq.strobe = 1'b1;
        busReq.addr   = a;
        @(posedge clk);
        #1;
        busReq.strobe = 1'b0;
        busReq.addr   = ~a;
        ok = 1'b0;
        d  = '0;
        // the ack stands for the cycle after the taking edge; look just
        // after each edge, where it has settled, and return there too
        for (i = 0; i < 6 && !ok; i++) begin
            if (busRsp.ackN === 1'b0) begin
                ok = 1'b1;
                d  = busRsp.data;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the acquisition sample memory: random sample
// words are stored through paced store ticks and read back relative to
// the last write. assumes the host model drives the read bus.
`default_nettype none
module tb_top
    import asm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk = 1'b0;
    logic                  reset;
    logic [SAMPLE_W-1:0]   convPos;
    logic [SAMPLE_W-1:0]   convNeg;
    logic                  smA;
    logic                  smB;
    logic                  acqGate;
    logic [SLOT_W-1:0]     slot;
    asm_bus_req_t          busReq;
    asm_bus_rsp_t          busRsp;
    logic                  rdN;
    logic                  wrEn;
    logic                  loN;
    logic                  hiN;
    logic [NUM_PHASE-1:0]  phase;
    logic                  aClk;
    logic [ADDR_W-1:0]     ramAddr;
    logic [13:0]           words [3];
    logic [BYTE_W-1:0]     d;
    logic                  ok;
    int                    badCount = 0;
    int                    nChecks = 0;
    int                    expPh = 0;
    int                    loCnt = 0;
    int                    hiCnt = 0;
    int                    acCnt = 0;

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    always #10 clk = ~clk;

    asm_acq_memory asm_acq_memory_i (
        .clk(clk), .reset(reset), .convPos(convPos), .convNeg(convNeg),
        .sample_mem_clk_a(smA), .sample_mem_clk_b(smB),
        .acq_gate(acqGate), .slot_ident(slot), .busReq(busReq),
        .busRsp(busRsp), .rd_path_en_n(rdN), .wr_path_en(wrEn),
        .wstrobe_lo_n(loN), .wstrobe_hi_n(hiN), .phase_clk(phase),
        .waddr_clk(aClk), .ramAddr(ramAddr)
    );

    asm_host_model asm_host_model_i (
        .clk(clk), .busReq(busReq), .busRsp(busRsp)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [BUS_ADDR_W-1:0] mkAddr(
            input logic [7:0] ofs, input logic typ, input logic [3:0] s);
        logic [BUS_ADDR_W-1:0] a;
        a        = '0;
        a[22:19] = s;
        a[10:3]  = ofs;
        a[1]     = typ;
        return a;
    endfunction

    // lane byte expected from one stored pair of converter words
    function automatic logic [7:0] expByte(input logic [13:0] w);
        return {1'b0, w[13:7] | w[6:0]};
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one store tick, alternating the two sample-memory clocks
    task automatic tick(input logic useB);
        smA = ~useB;
        smB = useB;
        step(3);
        smA = 1'b0;
        smB = 1'b0;
        step(3);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic typ,
                      input logic [7:0] expD, input logic [7:0] expRa);
        asm_host_model_i.read(mkAddr(ofs, typ, slot), d, ok);
        // the acknowledge still stands here, so the path signals are live
        check(ok, 1);
        check(d, expD);
        check(ramAddr, expRa);
        check(rdN, 0);
        check(wrEn, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watch phase order and strobes mid-cycle, where the flops have settled
    always @(negedge clk) begin
        if (reset === 1'b0) begin
            if (phase !== '0) begin
                check(phase, 4'h1 << expPh);
                expPh = (expPh + 1) % 4;
            end
            if (loN === 1'b0)
                loCnt++;
            if (hiN === 1'b0 || aClk === 1'b1) begin
                hiCnt++;
                check({hiN, aClk}, 2'h1);
            end
            if (aClk === 1'b1)
                acCnt++;
        end
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        closeOut();
    end

    // main sequence
    initial begin
        void'($urandom(32'h9753a17f));
        reset   = 1'b1;
        convPos = '0;
        convNeg = '0;
        smA     = 1'b0;
        smB     = 1'b0;
        acqGate = 1'b0;
        slot    = 4'($urandom);
        step(16);
        reset = 1'b0;
        step(1);
        check({busRsp, rdN, wrEn, loN, hiN, phase, aClk, ramAddr},
              {1'b1, 8'h00, 4'hf, 4'h0, 1'b0, 8'h00});
        rd(8'h00, 1'b1, {4'h0, BOARD_TYPE}, 8'h00);
        asm_host_model_i.read(mkAddr(8'h00, 1'b0, slot ^ 4'h8), d, ok);
        check(ok, 0);
        acqGate = 1'b1;
        step(6);
        // a fresh pair per tick, so only the first phase byte reads back
        for (int w = 0; w < 3; w++) begin
            for (int k = 0; k < 4; k++) begin
                {convPos, convNeg} = 14'($urandom);
                if (k == 0)
                    words[w] = {convPos, convNeg};
                tick(k[0]);
            end
            step(8);
        end
        acqGate = 1'b0;
        step(6);
        check(ramAddr, 8'h02);
        check(loCnt, 3);
        check(hiCnt, 3);
        check(acCnt, 3);
        for (int w = 0; w < 3; w++)
            rd(8'(w - 2), 1'b0, expByte(words[w]), 8'(w));
        convPos = 7'($urandom);
        for (int k = 0; k < 4; k++)
            tick(k[0]);
        step(6);
        check(acCnt, 3);
        check(loCnt, 3);
        rd(8'h00, 1'b0, expByte(words[2]), 8'h02);
        rd(8'hff, 1'b0, expByte(words[1]), 8'h01);
        closeOut();
    end
endmodule
`default_nettype wire
